/* File: hw/timer_mode_defines.vh */
// Purpose: Constants for the standard timer unit with mode and pin control.
// Assumes: 100 MHz core clock, Avalon-MM word-addressed register slave.
// Notes:   Offsets are word addresses of 32-bit words.
`ifndef TIMER_MODE_DEFINES_VH
`define TIMER_MODE_DEFINES_VH

`define OFS_CONTROL          4'h0
`define OFS_MODE_PIN         4'h1
`define OFS_COUNT            4'h2
`define OFS_COMPARE_A        4'h3
`define OFS_COMPARE_P        4'h4
`define OFS_CAPTURE          4'h5

`define ADDR_W               4

`define CTRL_ON_BIT          3
`define CTRL_RESET           8'h00

`define MP_MODE_HI           7
`define MP_MODE_LO           6
`define MP_FUNC_HI           5
`define MP_FUNC_LO           4
`define MP_INIT_LEVEL        3
`define MP_INVERT            2
`define MP_DUTY_PERIOD       1
`define MP_CNT_CLEAR         0
`define MP_RESET             8'h00

`define MODE_COMPARE         2'h0
`define MODE_CAPTURE         2'h1
`define MODE_PWM             2'h2
`define MODE_TIMER           2'h3

`define FUNC_0               2'h0
`define FUNC_1               2'h1
`define FUNC_2               2'h2
`define FUNC_3               2'h3

`define COUNT_RESET          16'h0000
`define CMP_A_RESET          16'h0000
`define CMP_P_RESET          8'h00

`endif

/* File: hw/timer_pin_edge.v */
// Purpose: Edge detector for the capture input pin.
// Assumes: Pin input is synchronous to core_clk_i.
// Notes:   Edge selection is decided by the caller.
`timescale 1ns/10ps
module timer_pin_edge (
   input  wire core_clk_i,
   input  wire resetn_i,
   input  wire pin_i,
   output wire rise_o,
   output wire fall_o
);
   reg pin_prev;

   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_i;
      end
   end

   assign rise_o = pin_i & ~pin_prev;
   assign fall_o = ~pin_i & pin_prev;
endmodule

/* File: hw/timer_mode_output_control.v */
// Purpose: Standard 16-bit timer unit with mode and pin-function control.
// Assumes: One 100 MHz clock; counter advances every clock while on.
// Notes:   Registers on Avalon-MM, one aligned word each, one wait state.
//          Clear select picks the P or A match; PWM wraps at the selected period.
// Functional notes
// - Mode field: 00 compare, 01 capture, 10 PWM/single pulse, 11 timer.
// - Timer/counter mode leaves the output pin undriven.
// - Compare match A: 00 no change, 01 low, 10 high, 11 toggle.
// - PWM mode: 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - Capture mode: 00 rising, 01 falling, 10 both edges, 11 disabled.
// - Compare mode initial pin level follows the output-control bit.
// - PWM mode output-control bit: 0 active low, 1 active high.
// - Output-control bit has no effect in timer/counter mode.
// - Match requesting the initial level gives no visible change.
// - On bit rising edge returns the compare pin to its initial level.
// - Polarity bit 0 passes the output uninverted.
// - Polarity bit 1 inverts the output; no effect in timer mode.
// - On bit rising clears counter; clearing the bit stops and keeps it.
`timescale 1ns/10ps
`include "timer_mode_defines.vh"
module timer_mode_output_control (
   input  wire        core_clk_i,
   input  wire        resetn_i,
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output reg         waitrequest,
   input  wire        capture_input_pin_i,
   output reg         timer_output_pin_o,
   output reg         timer_output_pin_oe_n_o,
   output reg         capture_event_o
);
   reg  [7:0]  control;
   reg  [7:0]  timer_mode_pin_control;
   reg  [15:0] count;
   reg  [15:0] compare_a;
   reg  [7:0]  compare_p;
   reg  [15:0] capture_value;
   reg         module_on_prev;
   reg         cmp_level;
   reg         pulse_done;
   reg         req_ack;
   reg  [31:0] next_readdata;
   reg         next_pin;
   reg         next_level;

   wire        module_on            = control[`CTRL_ON_BIT];
   wire [1:0]  op_mode              = {timer_mode_pin_control[`MP_MODE_HI],
                                       timer_mode_pin_control[`MP_MODE_LO]};
   wire [1:0]  pin_func             = {timer_mode_pin_control[`MP_FUNC_HI],
                                       timer_mode_pin_control[`MP_FUNC_LO]};
   wire        output_initial_level = timer_mode_pin_control[`MP_INIT_LEVEL];
   wire        output_invert        = timer_mode_pin_control[`MP_INVERT];
   wire        duty_period_select   = timer_mode_pin_control[`MP_DUTY_PERIOD];
   wire        counter_clear_select = timer_mode_pin_control[`MP_CNT_CLEAR];
   wire        on_rise              = module_on & ~module_on_prev;
   // Matches only count while the module runs
   wire        match_a              = module_on & (count == compare_a);
   wire        match_p              = module_on & (count[15:8] == compare_p);
   wire        pin_rise;
   wire        pin_fall;
   wire        access               = (read | write) & ~req_ack;
   wire        wr_en                = write & req_ack;
   reg         cap_hit;
   reg         clear_now;
   reg         pwm_active;
   wire [15:0] duty_val             = duty_period_select ? {compare_p, 8'h00} : compare_a;
   wire [15:0] period_val           = duty_period_select ? compare_a : {compare_p, 8'h00};

   // Capture pin edges, flagged in the same cycle that the pin moves
   timer_pin_edge u_edge (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .pin_i      (capture_input_pin_i),
      .rise_o     (pin_rise),
      .fall_o     (pin_fall)
   );

   // Capture edge selection; code 11 turns capture off entirely
   // so a noisy pin cannot disturb the held capture value
   always @* begin
      case (pin_func)
         `FUNC_0: begin
            cap_hit = pin_rise;
         end
         `FUNC_1: begin
            cap_hit = pin_fall;
         end
         `FUNC_2: begin
            cap_hit = pin_rise | pin_fall;
         end
         default: begin
            cap_hit = 1'b0;
         end
      endcase
   end

   // Counter clear source: compare P or A match, chosen by clear select;
   // PWM mode always wraps at the selected period instead
   always @* begin
      if (op_mode == `MODE_PWM) begin
         clear_now = module_on & (count == period_val);
      end else if (counter_clear_select) begin
         clear_now = match_a;
      end else begin
         clear_now = match_p;
      end
   end

   // Up counter; switch-on clears it before any match can be seen
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count          <= `COUNT_RESET;
         module_on_prev <= 1'b0;
         capture_value  <= `COUNT_RESET;
      end else begin
         module_on_prev <= module_on;
         if (on_rise) begin
            count <= `COUNT_RESET;
         end else if (module_on) begin
            if (clear_now) begin
               count <= `COUNT_RESET;
            end else begin
               count <= count + 16'h0001;
            end
         end
         if (module_on && op_mode == `MODE_CAPTURE && cap_hit) begin
            capture_value <= count;
         end
      end
   end

   // Compare-mode pin level; reloaded from the initial level on switch-on
   always @* begin
      next_level = cmp_level;
      if (on_rise) begin
         next_level = output_initial_level;
      end else if (match_a) begin
         case (pin_func)
            `FUNC_0: begin
               next_level = cmp_level;
            end
            `FUNC_1: begin
               next_level = 1'b0;
            end
            `FUNC_2: begin
               next_level = 1'b1;
            end
            default: begin
               next_level = ~cmp_level;
            end
         endcase
      end
   end

   // Outside compare mode the level is preloaded, so a later switch to
   // compare mode starts from the initial level. The single pulse ends at
   // the first compare A match and rearms on switch-on.
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmp_level  <= 1'b0;
         pulse_done <= 1'b0;
      end else begin
         if (op_mode == `MODE_COMPARE) begin
            cmp_level <= next_level;
         end else begin
            cmp_level <= output_initial_level;
         end
         if (on_rise || !module_on) begin
            pulse_done <= 1'b0;
         end else if (match_a) begin
            pulse_done <= 1'b1;
         end
      end
   end

   // Active phase of the generated waveform
   always @* begin
      case (pin_func)
         `FUNC_0: begin
            pwm_active = 1'b0;
         end
         `FUNC_1: begin
            pwm_active = 1'b1;
         end
         `FUNC_2: begin
            pwm_active = module_on & (count < duty_val);
         end
         default: begin
            pwm_active = module_on & ~pulse_done & ~on_rise;
         end
      endcase
   end

   // Output pin selection, level mapping and polarity
   always @* begin
      case (op_mode)
         `MODE_COMPARE: begin
            next_pin = cmp_level;
         end
         `MODE_PWM: begin
            next_pin = output_initial_level ? pwm_active : ~pwm_active;
         end
         default: begin
            next_pin = 1'b0;
         end
      endcase
      // Polarity acts on the level that the mode produced; timer mode then forces 0
      next_pin = next_pin ^ output_invert;
      if (op_mode == `MODE_TIMER) begin
         next_pin = 1'b0;
      end
   end

   // Pin, enable and capture strobe are registered so outputs never glitch
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         timer_output_pin_o      <= 1'b0;
         timer_output_pin_oe_n_o <= 1'b1;
         capture_event_o         <= 1'b0;
      end else begin
         timer_output_pin_o      <= next_pin;
         timer_output_pin_oe_n_o <= (op_mode == `MODE_TIMER) ||
                                    (op_mode == `MODE_CAPTURE);
         capture_event_o         <= module_on & (op_mode == `MODE_CAPTURE) & cap_hit;
      end
   end

   // Register read mux
   always @* begin
      case (address)
         `OFS_CONTROL: begin
            next_readdata = {24'h00_0000, control};
         end
         `OFS_MODE_PIN: begin
            next_readdata = {24'h00_0000, timer_mode_pin_control};
         end
         `OFS_COUNT: begin
            next_readdata = {16'h0000, count};
         end
         `OFS_COMPARE_A: begin
            next_readdata = {16'h0000, compare_a};
         end
         `OFS_COMPARE_P: begin
            next_readdata = {24'h00_0000, compare_p};
         end
         `OFS_CAPTURE: begin
            next_readdata = {16'h0000, capture_value};
         end
         default: begin
            next_readdata = 32'h0000_0000;
         end
      endcase
   end

   // Avalon handshake: a request is taken, answered one cycle later, and
   // access is blocked during that answer cycle so a held request is never taken twice
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_ack     <= 1'b0;
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else begin
         req_ack     <= access;
         waitrequest <= ~access;
         if (access && read) begin
            readdata <= next_readdata;
         end
      end
   end

   // Register writes land on the edge where waitrequest is seen low
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         control                <= `CTRL_RESET;
         timer_mode_pin_control <= `MP_RESET;
         compare_a              <= `CMP_A_RESET;
         compare_p              <= `CMP_P_RESET;
      end else if (wr_en) begin
         case (address)
            `OFS_CONTROL: begin
               // Bits 2:0 are unused and always read back as zero
               control <= writedata[7:0] & 8'hF8;
            end
            `OFS_MODE_PIN: begin
               timer_mode_pin_control <= writedata[7:0];
            end
            `OFS_COMPARE_A: begin
               compare_a <= writedata[15:0];
            end
            `OFS_COMPARE_P: begin
               compare_p <= writedata[7:0];
            end
            default: begin
               // Writes to unmapped or read-only words are dropped
               control <= control;
            end
         endcase
      end
   end
endmodule

/* File: test/timer_mode_output_control_sva.sv */
// Purpose: Port checks for the timer mode and pin control block.
// Assumes: Mode field is tracked from completed writes to word 1.
// Notes:   One clock domain, asynchronous active-low reset.
`timescale 1ns/10ps
module timer_mode_output_control_sva (
   input wire        core_clk_i,
   input wire        resetn_i,
   input wire [3:0]  address,
   input wire        read,
   input wire        write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire        waitrequest,
   input wire        capture_input_pin_i,
   input wire        timer_output_pin_o,
   input wire        timer_output_pin_oe_n_o,
   input wire        capture_event_o
);
   logic [7:0] mp;
   always @(posedge core_clk_i or negedge resetn_i)
      if (!resetn_i) mp <= 8'h00;
      else if (write && !waitrequest && address == 4'h1) mp <= writedata[7:0];
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_req; (read || write) && waitrequest; endsequence
   sequence s_mode(m); (mp[7:6] == m) [*3]; endsequence
   sequence s_cap(f); (mp[7:4] == {2'h1, f}) [*3]; endsequence
   a_wait_one_cycle: assert property (s_req |=> !waitrequest)
      else $error("access not answered after one wait cycle");
   a_wait_short: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_compare_drives: assert property (s_mode(2'h0) |-> !timer_output_pin_oe_n_o)
      else $error("compare mode does not drive the pin");
   a_timer_release: assert property (s_mode(2'h3) |-> timer_output_pin_oe_n_o)
      else $error("timer mode drives the pin");
   a_capture_release: assert property (s_mode(2'h1) |-> timer_output_pin_oe_n_o)
      else $error("capture mode drives the pin");
   a_cap_disabled: assert property (s_cap(2'h3) |-> !capture_event_o)
      else $error("capture taken while disabled");
   a_cap_rise: assert property (s_cap(2'h0) ##0 $rose(capture_input_pin_i)
      |-> ##[1:3] capture_event_o)
      else $error("rising edge not captured");
   a_cap_fall_only: assert property (s_cap(2'h1) ##0 $rose(capture_input_pin_i)
      |-> ##1 !capture_event_o [*3])
      else $error("rising edge captured in falling mode");
   a_unmapped_zero: assert property (read && !waitrequest && address > 4'h5
      |-> readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule

/* File: test/pin_partner.sv */
// Purpose: Far-side driver of the capture input pin.
// Assumes: Pin level changes just after a clock edge.
// Notes:   Follows the bench request one cycle later.
`timescale 1ns/10ps
module pin_partner (
   input  wire  core_clk_i,
   input  wire  want_i,
   output logic cap_pin_o
);
   initial cap_pin_o = 1'b0;
   always @(posedge core_clk_i) cap_pin_o <= want_i;
endmodule

/* File: test/timer_mode_output_control_tb_top.sv */
// Purpose: Self-checking bench for the timer mode and pin control block.
// Assumes: Avalon slave with one wait cycle, mode set only while off.
// Notes:   Compare, PWM, timer and capture modes are swept.
`timescale 1ns/10ps
module timer_mode_output_control_tb_top;
   logic        core_clk_i = 0;
   logic        resetn_i   = 0;
   logic [3:0]  address    = 4'h0;
   logic        read       = 0;
   logic        write      = 0;
   logic [31:0] writedata  = 32'h0000_0000;
   logic        want       = 0;
   logic [31:0] q;
   wire  [31:0] readdata;
   wire         waitrequest, pin, oe_n, cap_ev, cap_pin;
   int          err_count  = 0;
   int          tests_run  = 0;
   int          cycles     = 0;
   always #5 core_clk_i = ~core_clk_i;
   timer_mode_output_control dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .capture_input_pin_i(cap_pin),
      .timer_output_pin_o(pin), .timer_output_pin_oe_n_o(oe_n), .capture_event_o(cap_ev));
   pin_partner pin_u (.core_clk_i(core_clk_i), .want_i(want), .cap_pin_o(cap_pin));
   task close_out;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         close_out;
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      write <= w;
      read <= !w;
      address <= a;
      writedata <= d;
      do @(posedge core_clk_i); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task rdc(input string n, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(n, e, q);
   endtask
   task t_regs;
      rdc("mode_pin", 4'h1, 32'h0000_0000);
      rdc("control", 4'h0, 32'h0000_0000);
      bus(1'b1, 4'h0, 32'h0000_000F);
      rdc("control", 4'h0, 32'h0000_0008);
      bus(1'b1, 4'h0, 32'h0000_0000);
      bus(1'b1, 4'h1, 32'h0000_00A5);
      bus(1'b1, 4'hF, 32'h0000_005A);
      rdc("mode_pin", 4'h1, 32'h0000_00A5);
      rdc("unmapped", 4'hF, 32'h0000_0000);
   endtask
   task t_compare;
      logic [3:0] k;
      logic       e;
      bus(1'b1, 4'h3, 32'h0000_0005);
      bus(1'b1, 4'h4, 32'h0000_00FF);
      for (int j = 0; j < 9; j++) begin
         k = j[3:0];
         bus(1'b1, 4'h0, 32'h0000_0000);
         bus(1'b1, 4'h1, {24'h0000_00, 2'h0, k[1:0], k[2], k[3], 2'h0});
         bus(1'b1, 4'h0, 32'h0000_0008);
         cyc(3);
         chk("pin_init", k[2] ^ k[3], pin);
         cyc(20);
         e = (k[1:0] == 2'h0) ? k[2] : (k[1:0] == 2'h3) ? !k[2] : k[1];
         chk("pin_match", e ^ k[3], pin);
      end
   endtask
   task t_pwm;
      logic [2:0] k;
      bus(1'b1, 4'h3, 32'h0000_0014);
      bus(1'b1, 4'h4, 32'h0000_0001);
      for (int j = 0; j < 8; j++) begin
         k = j[2:0];
         bus(1'b1, 4'h0, 32'h0000_0000);
         bus(1'b1, 4'h1, {24'h0000_00, 2'h2, k[1:0], k[2], 3'h0});
         bus(1'b1, 4'h0, 32'h0000_0008);
         cyc(4);
         chk("pwm_early", (k[1:0] != 2'h0) == k[2], pin);
         cyc(40);
         chk("pwm_late", (k[1:0] == 2'h1) == k[2], pin);
      end
   endtask
   task t_timer;
      logic [31:0] keep;
      bus(1'b1, 4'h0, 32'h0000_0000);
      bus(1'b1, 4'h1, 32'h0000_00CC);
      bus(1'b1, 4'h0, 32'h0000_0008);
      cyc(30);
      chk("oe_timer", 1'b1, oe_n);
      bus(1'b1, 4'h0, 32'h0000_0000);
      bus(1'b0, 4'h2, 32'h0000_0000);
      keep = q;
      cyc(5);
      rdc("count_hold", 4'h2, keep);
      bus(1'b1, 4'h0, 32'h0000_0008);
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk("count_clear", 1'b1, q < 32'h0000_0008);
   endtask
   task t_capture;
      int n;
      for (int f = 0; f < 4; f++) begin
         bus(1'b1, 4'h0, 32'h0000_0000);
         bus(1'b1, 4'h1, {24'h0000_00, 2'h1, f[1:0], 4'h0});
         bus(1'b1, 4'h0, 32'h0000_0008);
         for (int s = 1; s >= 0; s--) begin
            n = 0;
            want <= s[0];
            repeat (10) begin
               @(posedge core_clk_i);
               n += cap_ev;
            end
            chk("cap_events", (f == 2) || (f == (s ? 0 : 1)), n);
         end
      end
   endtask
   initial begin
      cyc(20);
      resetn_i <= 1'b1;
      cyc(2);
      t_regs;
      t_compare;
      t_pwm;
      t_timer;
      t_capture;
      close_out;
   end
endmodule
bind timer_mode_output_control timer_mode_output_control_sva chk_u (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .capture_input_pin_i(capture_input_pin_i), .timer_output_pin_o(timer_output_pin_o),
   .timer_output_pin_oe_n_o(timer_output_pin_oe_n_o), .capture_event_o(capture_event_o));
